/* File: dv/psc_bus_master.sv */
// psc_bus_master.sv: external bus master model
// assumes go_i and hold_i from the bench, same clock
`timescale 1ns/10ps
module psc_bus_master (
  input  wire       clock_i,
  input  wire       go_i,
  input  wire [1:0] hold_i,
  input  wire       bus_grant_n_i,
  output reg        bus_request_n_o
);
  // ----------------------------------------------------------
  // request, hold while granted, release
  // ----------------------------------------------------------
  reg [1:0] cnt = 2'h0;
  initial bus_request_n_o = 1'b1;
  // hold_i of zero answers promptly, larger values stall the device
  always @(posedge clock_i) begin
    // a new request only once the previous grant is seen high
    if (bus_request_n_o && go_i && bus_grant_n_i) begin
      bus_request_n_o <= #2 1'b0;
      cnt <= hold_i;
    end else if (!bus_request_n_o && !bus_grant_n_i) begin
      if (cnt == 2'h0) bus_request_n_o <= #2 1'b1;
      else cnt <= cnt - 2'h1;
    end
  end
endmodule

/* File: dv/psc_control_properties.sv */
// psc_control_properties.sv: port checker for psc_control
// assumes psc_control instances in the bench; bound below
`timescale 1ns/10ps
module psc_props (
  input wire       clock_i,
  input wire       rst_i,
  input wire       bus_request_n_i,
  input wire       need_bus_i,
  input wire       proc_clock_out_o,
  input wire       core_reset_o,
  input wire [2:0] boot_mode_o,
  input wire       flag_output_0_o,
  input wire       strobes_oe_o,
  input wire       bus_grant_n_o,
  input wire       grant_hang_n_o
);
  // ----------------------------------------------------------
  // clock, flag and bus handshake relations
  // ----------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // realign may hold one extra cycle, never two
  a_clk_toggle: assert property ($stable(proc_clock_out_o)
    |=> !$stable(proc_clock_out_o)) else $error("clock stuck");
  a_flag_fall: assert property (!$stable(flag_output_0_o)
    |-> $past(proc_clock_out_o) && !proc_clock_out_o) else $error("flag");
  a_float_first: assert property ($fell(bus_grant_n_o)
    |-> !strobes_oe_o && !$past(strobes_oe_o)) else $error("oe at grant");
  a_grant_first: assert property ($rose(strobes_oe_o)
    |-> bus_grant_n_o && $past(bus_grant_n_o)) else $error("oe early");
  a_hang_float: assert property (!grant_hang_n_o
    |-> !bus_grant_n_o && !strobes_oe_o) else $error("hang");
  a_hang_need: assert property (!grant_hang_n_o
    |-> $past(need_bus_i)) else $error("hang without need");
  a_grant_held: assert property (!bus_grant_n_o && !bus_request_n_i
    |=> !bus_grant_n_o) else $error("grant dropped");
  a_req_taken: assert property ((!bus_request_n_i && !core_reset_o)[*8]
    |-> !bus_grant_n_o) else $error("request ignored");
  a_mode_held: assert property (!core_reset_o && !$past(core_reset_o)
    |-> $stable(boot_mode_o)) else $error("mode moved");
  c_grant: cover property ($fell(bus_grant_n_o));
  c_hang: cover property (!grant_hang_n_o);
  c_boot: cover property ($fell(core_reset_o));
endmodule
bind psc_control psc_props psc_props_i (.clock_i(clock_i), .rst_i(rst_i),
  .bus_request_n_i(bus_request_n_i), .need_bus_i(need_bus_i),
  .proc_clock_out_o(proc_clock_out_o),
  .core_reset_o(core_reset_o), .boot_mode_o(boot_mode_o),
  .flag_output_0_o(flag_output_0_o), .strobes_oe_o(strobes_oe_o),
  .bus_grant_n_o(bus_grant_n_o), .grant_hang_n_o(grant_hang_n_o));

/* File: dv/tb_top.sv */
// tb_top.sv: self-checking bench for psc_control
// assumes psc_props bound by its own file, 25 MHz clock
`timescale 1ns/10ps
module tb_top;
  reg clock_i = 1'b0, rst_i = 1'b1, ext_clock_in_i = 1'b0, ec = 1'b0;
  reg go = 1'b0, cr_p = 1'b1, bg_p = 1'b1, nb = 1'b1, sfi = 1'b0;
  reg [7:0] fl_q[$], pf_p = 8'h00, fe;
  wire [7:0] prog_flag_pins_o, prog_flag_pins_oe_o;
  wire flag_output_1_o, flag_output_2_o, serial_flag_out_o;
  reg [5:0] ext_interrupt_inputs_n_i = 6'h3F, irq_clear_i = 6'h00;
  reg [5:0] ip_p = 6'h00;
  reg [7:0] prog_flag_pins_i = 8'h00, pf = 8'h00;
  reg [6:0] strobes_n_i = 7'h7F;
  reg [1:0] hold = 2'h0;
  reg [7:0] mode_q[$], irq_q[$], bus_q[$];
  wire proc_clock_out_o, core_reset_o, strobes_oe_o, bus_request_n_i;
  wire flag_output_0_o, bus_grant_n_o, grant_hang_n_o;
  wire [2:0] boot_mode_o;
  wire [5:0] irq_pending_o;
  integer fail_count = 0, cmp_count = 0, seed = 5, i, n;
  psc_control #(.LOCK_CYC(20)) psc_control_i (
    .clock_i(clock_i), .rst_i(rst_i), .ext_clock_in_i(ext_clock_in_i),
    .bus_request_n_i(bus_request_n_i), .need_bus_i(nb),
    .ext_interrupt_inputs_n_i(ext_interrupt_inputs_n_i),
    .serial_flag_input_i(sfi), .prog_flag_pins_i(prog_flag_pins_i),
    .pf_out_val_i(pf), .pf_out_en_i(8'hFF), .flag_out_val_i(pf[2:0]),
    .serial_flag_val_i(pf[3]), .strobes_n_i(strobes_n_i),
    .irq_clear_i(irq_clear_i), .proc_clock_out_o(proc_clock_out_o),
    .core_reset_o(core_reset_o), .pll_locked_o(), .boot_mode_o(boot_mode_o),
    .irq_pending_o(irq_pending_o), .serial_flag_o(), .pf_sampled_o(),
    .prog_flag_pins_o(prog_flag_pins_o),
    .prog_flag_pins_oe_o(prog_flag_pins_oe_o),
    .flag_output_0_o(flag_output_0_o), .flag_output_1_o(flag_output_1_o),
    .flag_output_2_o(flag_output_2_o),
    .serial_flag_out_o(serial_flag_out_o), .strobes_n_o(),
    .strobes_oe_o(strobes_oe_o), .bus_grant_n_o(bus_grant_n_o),
    .grant_hang_n_o(grant_hang_n_o));
  psc_bus_master psc_bus_master_i (.clock_i(clock_i), .go_i(go),
    .hold_i(hold), .bus_grant_n_i(bus_grant_n_o),
    .bus_request_n_o(bus_request_n_i));
  // ----------------------------------------------------------
  // clocks, tasks, watcher
  // ----------------------------------------------------------
  always #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    ec <= ~ec;
    if (ec) ext_clock_in_i <= #2 ~ext_clock_in_i;
  end
  task cyc(input integer k);
    repeat (k) @(posedge clock_i);
    #2;
  endtask
  task chk(input [8*8:1] nm, input [7:0] e, input [7:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
    end
  endtask
  task stop_test;
    // a note left unanswered means an expected result never came
    if (mode_q.size() + irq_q.size() + bus_q.size() + fl_q.size() != 0)
      fail_count = fail_count + 1;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock_i) begin
    #1;
    if (cr_p === 1'b1 && core_reset_o === 1'b0)
      chk("mode", mode_q.pop_front(), boot_mode_o);
    if (!rst_i && (irq_pending_o & ~ip_p) !== 6'h00)
      chk("irq", irq_q.pop_front(), irq_pending_o);
    if (bg_p !== bus_grant_n_o && !rst_i)
      chk("oe", bus_q.pop_front(), strobes_oe_o);
    if (!rst_i && prog_flag_pins_o !== pf_p) begin
      fe = fl_q.pop_front();
      chk("pf", fe, prog_flag_pins_o);
      chk("fl", {4'h0, fe[3:0]}, {4'h0, serial_flag_out_o,
          flag_output_2_o, flag_output_1_o, flag_output_0_o});
      chk("pf_oe", 8'hFF, prog_flag_pins_oe_o);
    end
    pf_p = prog_flag_pins_o;
    cr_p = core_reset_o;
    ip_p = irq_pending_o;
    bg_p = bus_grant_n_o;
  end
  initial begin
    #100000;
    fail_count = fail_count + 1;
    stop_test;
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    // straps steady through the synchroniser flush
    for (i = 0; i < 2; i = i + 1) begin
      prog_flag_pins_i = $random(seed);
      mode_q.push_back(prog_flag_pins_i[2:0]);
      rst_i = 1'b1;
      cyc(5);
      rst_i = 1'b0;
      cyc(30);
    end
    for (i = 0; i < 6; i = i + 1) begin
      irq_q.push_back(6'h01 << i);
      ext_interrupt_inputs_n_i[i] = 1'b0;
      cyc((i == 3 || i == 4) ? 8 : 3);
      ext_interrupt_inputs_n_i[i] = 1'b1;
      cyc(5);
      irq_clear_i = 6'h01 << i;
      cyc(1);
      irq_clear_i = 6'h00;
      cyc(3);
    end
    go = 1'b1; // requests again as soon as the grant is seen high after each release
    for (i = 0; i < 4; i = i + 1) begin
      hold = $random(seed);
      strobes_n_i = $random(seed);
      pf = pf ^ ($random(seed) | 1);
      fl_q.push_back(pf);
      nb = $random(seed);
      sfi = $random(seed);
      bus_q.push_back(8'h00);
      bus_q.push_back(8'h00);
      for (n = 0; n < 20 && bus_grant_n_o !== 1'b0; n = n + 1) cyc(1);
      for (n = 0; n < 20 && bus_grant_n_o !== 1'b1; n = n + 1) cyc(1);
    end
    go = 1'b0;
    cyc(10);
    stop_test;
  end
endmodule

/* File: verilog/psc_control.v */
// psc_control.v: processor clock, reset qualifying, boot straps,
// interrupt and flag sampling, bus request and grant handshake
// assumes clock_i is the doubled processor cycle, rst_i synchronous
`timescale 1ns/10ps
`include "psc_defines.vh"
module psc_control #(
  parameter LOCK_CYC = `PSC_LOCK_CYC
) (
  input  wire                   clock_i,
  input  wire                   rst_i,
  input  wire                   ext_clock_in_i,
  input  wire                   bus_request_n_i,
  input  wire                   need_bus_i,
  input  wire [`PSC_IRQ_W-1:0]  ext_interrupt_inputs_n_i,
  input  wire                   serial_flag_input_i,
  input  wire [`PSC_PF_W-1:0]   prog_flag_pins_i,
  input  wire [`PSC_PF_W-1:0]   pf_out_val_i,
  input  wire [`PSC_PF_W-1:0]   pf_out_en_i,
  input  wire [2:0]             flag_out_val_i,
  input  wire                   serial_flag_val_i,
  input  wire [`PSC_SEL_W+1:0]  strobes_n_i,
  input  wire [`PSC_IRQ_W-1:0]  irq_clear_i,
  output reg                    proc_clock_out_o,
  output reg                    core_reset_o,
  output reg                    pll_locked_o,
  output reg  [`PSC_MODE_W-1:0] boot_mode_o,
  output reg  [`PSC_IRQ_W-1:0]  irq_pending_o,
  output reg                    serial_flag_o,
  output reg  [`PSC_PF_W-1:0]   pf_sampled_o,
  output reg  [`PSC_PF_W-1:0]   prog_flag_pins_o,
  output reg  [`PSC_PF_W-1:0]   prog_flag_pins_oe_o,
  output reg                    flag_output_0_o,
  output reg                    flag_output_1_o,
  output reg                    flag_output_2_o,
  output reg                    serial_flag_out_o,
  output reg  [`PSC_SEL_W+1:0]  strobes_n_o,
  output reg                    strobes_oe_o,
  output reg                    bus_grant_n_o,
  output reg                    grant_hang_n_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire                  ck_s;
  wire                  br_n_s;
  wire [`PSC_IRQ_W-1:0] irq_n_s;
  wire                  fi_s;
  wire [`PSC_PF_W-1:0]  pf_s;

  psc_sync #(.W(`PSC_IRQ_W + `PSC_PF_W + 3)) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     ({ext_clock_in_i, bus_request_n_i, serial_flag_input_i,
               ext_interrupt_inputs_n_i, prog_flag_pins_i}),
    .q_o     ({ck_s, br_n_s, fi_s, irq_n_s, pf_s})
  );

  // ----------------------------------------------------------------
  // processor clock and cycle enable
  // ----------------------------------------------------------------
  // output clock toggles each clock_i unless a realign finds it high: one processor cycle per two
  // clock_i edges, the input clock period being two processor cycles
  reg  ck_d;
  // a realign holds the output high, so that edge is no fall
  wire realign = ck_s & ~ck_d;
  wire fall_en = proc_clock_out_o & ~realign;
  wire rise_en = ~proc_clock_out_o;

  always @(posedge clock_i) begin
    if (rst_i) begin
      proc_clock_out_o <= 1'b0;
      // matches the synchroniser reset level: no false edge after reset
      ck_d             <= 1'b1;
    end else begin
      ck_d <= ck_s;
      // realign so the output rises with each input clock rise
      if (realign) begin
        proc_clock_out_o <= 1'b1;
      end else begin
        proc_clock_out_o <= ~proc_clock_out_o;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset qualifying and boot straps
  // ----------------------------------------------------------------
  // counted in clock_i cycles, more than enough input cycles
  reg [`PSC_LOCK_W-1:0] lock_cnt;

  always @(posedge clock_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      boot_mode_o  <= `PSC_MODE_RST;
    end else begin
      core_reset_o <= ~pll_locked_o;
      // straps caught once, at the release edge only
      if (core_reset_o & pll_locked_o)
        boot_mode_o <= pf_s[`PSC_MODE_C_BIT:`PSC_MODE_A_BIT];
    end
  end

  // every reset restarts the lock wait; straps then pass the flush
  always @(posedge clock_i) begin
    if (rst_i) begin
      lock_cnt     <= {`PSC_LOCK_W{1'b0}};
      pll_locked_o <= 1'b0;
    end else if (!pll_locked_o) begin
      if (lock_cnt == LOCK_CYC[`PSC_LOCK_W-1:0] - 1'b1)
        pll_locked_o <= 1'b1;
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupts and flag inputs
  // ----------------------------------------------------------------
  // edge lines latch a falling edge; level lines follow the pin
  reg  [`PSC_IRQ_W-1:0] irq_d;
  wire [`PSC_IRQ_W-1:0] lvl_mask =
    ({{(`PSC_IRQ_W-1){1'b0}}, 1'b1} << `PSC_IRQ_LVL0) |
    ({{(`PSC_IRQ_W-1){1'b0}}, 1'b1} << `PSC_IRQ_LVL1);
  wire [`PSC_IRQ_W-1:0] edge_hit = irq_d & ~irq_n_s & ~lvl_mask;

  always @(posedge clock_i) begin
    if (rst_i) begin
      irq_d         <= {`PSC_IRQ_W{1'b1}};
      irq_pending_o <= {`PSC_IRQ_W{1'b0}};
      serial_flag_o <= 1'b0;
      pf_sampled_o  <= {`PSC_PF_W{1'b0}};
    end else begin
      irq_d <= irq_n_s;
      // set wins over clear for edge lines
      irq_pending_o <= (lvl_mask & ~irq_n_s) |
                       (~lvl_mask & ((irq_pending_o & ~irq_clear_i)
                                     | edge_hit));
      // sampled at each cycle: a miss is taken next cycle
      if (fall_en) begin
        serial_flag_o <= fi_s;
        pf_sampled_o  <= pf_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // flag outputs
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      prog_flag_pins_o    <= {`PSC_PF_W{1'b0}};
      prog_flag_pins_oe_o <= {`PSC_PF_W{1'b0}};
      flag_output_0_o     <= 1'b0;
      flag_output_1_o     <= 1'b0;
      flag_output_2_o     <= 1'b0;
      serial_flag_out_o   <= 1'b0;
    end else if (fall_en) begin
      prog_flag_pins_o    <= pf_out_val_i;
      prog_flag_pins_oe_o <= pf_out_en_i & {`PSC_PF_W{~core_reset_o}};
      flag_output_0_o     <= flag_out_val_i[0];
      flag_output_1_o     <= flag_out_val_i[1];
      flag_output_2_o     <= flag_out_val_i[2];
      serial_flag_out_o   <= serial_flag_val_i;
    end
  end

  // ----------------------------------------------------------------
  // bus request and grant
  // ----------------------------------------------------------------
  localparam [3:0] ST_OWN   = 4'h1;
  localparam [3:0] ST_FLOAT = 4'h2;
  localparam [3:0] ST_GRANT = 4'h4;
  localparam [3:0] ST_BACK  = 4'h8;
  reg [3:0] state;
  reg [3:0] next_state;

  always @* begin
    case (state)
      ST_OWN:   next_state = (!br_n_s && rise_en) ? ST_FLOAT
                                                  : ST_OWN;
      ST_FLOAT: next_state = ST_GRANT;
      ST_GRANT: next_state = br_n_s ? ST_BACK : ST_GRANT;
      ST_BACK:  next_state = ST_OWN;
      default:  next_state = ST_OWN;
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      state          <= ST_OWN;
      strobes_oe_o   <= 1'b0;
      strobes_n_o    <= {(`PSC_SEL_W+2){1'b1}};
      bus_grant_n_o  <= 1'b1;
      grant_hang_n_o <= 1'b1;
    end else begin
      state       <= next_state;
      strobes_n_o <= strobes_n_i;
      // drives only after the grant is high again
      strobes_oe_o <= ~core_reset_o & (next_state == ST_OWN) &
                      (state != ST_BACK);
      // grant low one cycle after strobes float
      bus_grant_n_o <= ~(next_state == ST_GRANT);
      grant_hang_n_o <= ~((state == ST_GRANT) && (next_state == ST_GRANT)
                          && need_bus_i);
    end
  end
endmodule

/* File: verilog/psc_defines.vh */
// psc_defines.vh: constants for the processor system control pin block
// assumes a single 25 MHz clock_i; included by its bare name
// Operation
// - processor cycle runs at twice input clock
// - flag pins 2,1,0 carry boot mode C,B,A
// - inputs recognised this cycle or the next
// - six interrupt inputs, common sampling rule
// - flag outputs change on output clock fall
// - bus request synchronised before grant logic
// - bus request acted on this or next cycle
// - strobes float before grant goes low
// - grant goes high before strobes re-enable
// - grant hang asserted only after strobes float
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH
// ----------------------------------------------------------------
// widths and field positions
// ----------------------------------------------------------------
`define PSC_PF_W        8
`define PSC_IRQ_W       6
`define PSC_SEL_W       5
`define PSC_MODE_W      3
`define PSC_MODE_A_BIT  0
`define PSC_MODE_C_BIT  2
// irq vector order: general 0..2, level 0, level 1, extra edge
`define PSC_IRQ_LVL0    3
`define PSC_IRQ_LVL1    4
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define PSC_MODE_RST    3'h0
`define PSC_LOCK_CYC    2000
`define PSC_LOCK_W      11
`endif

/* File: verilog/psc_sync.v */
// psc_sync.v: two-stage synchroniser for a bus of pin inputs
// assumes inputs asynchronous to clock_i; no logic reads stage one
`timescale 1ns/10ps
module psc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b1}}
) (
  input  wire         clock_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta;

  always @(posedge clock_i) begin
    if (rst_i) begin
      meta <= RST;
      q_o  <= RST;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
